// ### core/line_codec_regs.vh
/*
  Constants for the line codec serial control and PCM port block:
  command classes and sub-codes, parameter store layout, reset values.
  Assumes it is included by bare name from the design file.
*/
`ifndef LINE_CODEC_REGS_VH
`define LINE_CODEC_REGS_VH
// whole-byte power commands
`define CMD_POWER_DOWN 8'h00
`define CMD_POWER_UP 8'hFF
// command classes (top three bits)
`define CLS_PDN 3'h0
`define CLS_TX_SLOT 3'h1
`define CLS_RX_SLOT 3'h2
`define CLS_CLK_GAIN 3'h3
`define CLS_FUNC 3'h4
`define CLS_COEF_TEST 3'h5
`define CLS_LATCH 3'h6
`define CLS_PUP 3'h7
// clock slot / gain class sub-codes
`define SUB_TXG_WR 5'h10
`define SUB_RXG_WR 5'h11
`define SUB_RD_TXSLOT 5'h12
`define SUB_RD_TXG 5'h13
`define SUB_RD_RXSLOT 5'h14
`define SUB_RD_RXG 5'h15
`define SUB_RD_MODE 5'h16
// coefficient / test class sub-codes
`define SUB_WR_B 5'h00
`define SUB_RD_B 5'h03
`define SUB_WR_X 5'h04
`define SUB_RD_X 5'h07
`define SUB_WR_R 5'h08
`define SUB_RD_R 5'h0B
`define SUB_WR_Z 5'h0C
`define SUB_RD_Z 5'h0F
`define SUB_NORMAL 5'h10
`define SUB_ATTN 5'h11
`define SUB_RXCUT 5'h12
`define SUB_HPF_OFF 5'h13
`define SUB_LOOP_DIG 5'h14
`define SUB_LOOP_ANA 5'h17
`define SUB_LINEAR 5'h18
`define SUB_MULAW 5'h19
// parameter store: first and last byte index of each set
`define BASE_B 6'h00
`define LAST_B 6'h0B
`define BASE_X 6'h0C
`define LAST_X 6'h13
`define BASE_R 6'h14
`define LAST_R 6'h1B
`define BASE_Z 6'h1C
`define LAST_Z 6'h23
`define BASE_TXG 6'h24
`define LAST_TXG 6'h25
`define BASE_RXG 6'h26
`define LAST_RXG 6'h27
`define STORE_WORDS 40
// readback sources
`define RD_STORE 2'h0
`define RD_TXSLOT 2'h1
`define RD_RXSLOT 2'h2
`define RD_MODE 2'h3
// reset values and fixed fields
`define RST_LATCH 5'h1F
`define RST_FILT 4'h0
`define MODE_TOP 4'hF
`define TX_ARM_SYNCS 2'h2
`define BITS_MU 5'h08
`define BITS_LIN 5'h10
`define POS_MAX 10'h3FF
`endif

// ### core/line_codec_serial_control.v
/*
  Serial command interpreter and PCM time-slot ports of a line codec,
  plus the small sample FIFO in front of the transmit port.
  Assumes a 25 MHz CORE_CLK far faster than the serial command clock and
  the PCM bit clocks, which are sampled as plain asynchronous inputs.
*/
`timescale 1ns/10ps
`include "line_codec_regs.vh"

// small synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // filling side
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  // draining side
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1]; // sample storage
  reg [AW-1:0] wp_r; // write pointer
  reg [AW-1:0] rp_r; // read pointer
  reg [AW:0] cnt_r; // words held
  wire push = in_valid & in_ready;
  wire pop = out_ready & out_valid;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  // pointers, count and a registered ready so the top sees a flop
  always @(posedge clk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        mem[wp_r] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != D[AW:0]);
    end
  end
endmodule

// Behaviour
// (R1) standby keeps settings, tristates PCM, ignores input
// (R2) power up clears data, waits two transmit syncs
// (R3) all-zero powers down, all-one powers up
// (R4) five-bit time slot, three-bit clock offset
// (R5) parameter bytes follow command, one per select
// (R6) readback one byte per select, commands ignored
// (R7) zero parameter byte powers down, zeroes last
// (R8) slot readback: time slot then clock slot
// (R9) mode readback: ones, rx/tx port, rx/tx expanded
// (R10) four filter enables; disabled filter forced
// (R11) mode command picks ports and expanded flags
// (R12) slot strobe open drain, low during burst
// (R13) normal conditions: gain, path, filter, no loop
// (R14) loopbacks exclusive; normal command cancels both
// (R15) coefficient nibble: sign and shift, 0000 illegal
// (R16) shaping and impedance sets are eight bytes
// (R17) balance set is twelve bytes
// (R18) digital loopback adds 6 dB; the code doubles looped samples in linear code only
// (R19) one transmit burst per frame, tristate otherwise
// (R20) one receive burst per frame, 8 or 16 bits
// (R21) frame syncs mark frame start for slot count
// (R22) data output released after readback; five latches
// (R23) top three bits class, low five sub-code
// (R24) serial bytes MSB first, one per select
// (R25) reserved commands change nothing
module line_codec_serial_control (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // serial command port
  input wire SER_CS_N,
  input wire SER_CMD_CLOCK,
  input wire SER_DIN,
  output reg SER_DOUT,
  output reg SER_DOUT_OE,
  // transmit highway
  input wire TX_FRAME_SYNC,
  input wire TX_BIT_CLOCK,
  output reg TX_PORT_FIRST,
  output reg TX_PORT_FIRST_OE,
  output reg TX_PORT_SECOND,
  output reg TX_PORT_SECOND_OE,
  output reg SLOT_STROBE_FIRST,
  output reg SLOT_STROBE_FIRST_OE,
  output reg SLOT_STROBE_SECOND,
  output reg SLOT_STROBE_SECOND_OE,
  // receive highway
  input wire RX_FRAME_SYNC,
  input wire RX_BIT_CLOCK,
  input wire RX_PORT_FIRST,
  input wire RX_PORT_SECOND,
  // transmit samples from the signal path
  input wire [15:0] TX_SAMPLE_DATA,
  input wire TX_SAMPLE_VALID,
  output wire TX_SAMPLE_READY,
  // receive samples to the signal path
  output reg [15:0] RX_SAMPLE_DATA,
  output reg RX_SAMPLE_VALID,
  // control state toward the signal path
  output reg POWERED_UP,
  output reg DATA_RAM_CLEAR,
  output reg [4:0] LATCHED_CONTROL_LINES,
  output reg [3:0] FILTER_ENABLES,
  output reg LINEAR_CODE,
  output reg RX_EXPANDED,
  output reg TX_EXPANDED,
  output reg LOOP_ANALOG,
  output reg LOOP_DIGITAL,
  output reg RX_ATTEN_6DB,
  output reg RX_PATH_CUT,
  output reg HPF_OFF,
  output reg CODE_ILLEGAL,
  output wire [15:0] TX_GAIN,
  output wire [15:0] RX_GAIN
);
  localparam ST_CMD = 2'h0; // expecting a command byte
  localparam ST_PARAM = 2'h1; // collecting parameter bytes
  localparam ST_READ = 2'h2; // handing out result bytes

  reg [7:0] store [0:`STORE_WORDS-1]; // coefficients then gains
  integer i;

  // serial port synchronisers and edge history
  reg cs_s1, cs_s2, cs_d;
  reg ck_s1, ck_s2, ck_d;
  reg di_s1, di_s2;
  reg [2:0] bit_cnt_r; // bits taken in this select window
  reg [6:0] shin_r; // first seven bits of the byte
  reg [7:0] shout_r; // result byte being shifted out
  reg [1:0] st_r; // interpreter state
  reg [5:0] idx_r; // next store index or readback step
  reg [5:0] last_r; // last index of the current transfer
  reg [1:0] rd_kind_r; // readback source
  reg [4:0] tx_ts_r, rx_ts_r; // time slots
  reg [2:0] tx_cs_r, rx_cs_r; // clock offsets
  reg rx_sel_r, tx_sel_r; // port B selects
  reg [7:0] rb_byte; // next readback byte

  wire ck_rise = ck_s2 & ~ck_d;
  wire ck_fall = ~ck_s2 & ck_d;
  wire cs_fall = ~cs_s2 & cs_d;
  wire cs_rise = cs_s2 & ~cs_d;
  wire byte_done = ck_rise & ~cs_s2 & (bit_cnt_r == 3'h7);
  wire [7:0] nb = {shin_r, di_s2}; // R24
  wire [4:0] sub = nb[4:0];

  assign TX_GAIN = {store[`BASE_TXG], store[`LAST_TXG]};
  assign RX_GAIN = {store[`BASE_RXG], store[`LAST_RXG]};

  // readback byte selection
  always @* begin
    case (rd_kind_r)
      `RD_TXSLOT: rb_byte = idx_r[0] ? {5'h00, tx_cs_r}
                                     : {3'h0, tx_ts_r}; // R8
      `RD_RXSLOT: rb_byte = idx_r[0] ? {5'h00, rx_cs_r}
                                     : {3'h0, rx_ts_r}; // R8
      `RD_MODE: rb_byte = {`MODE_TOP, rx_sel_r, tx_sel_r,
                           RX_EXPANDED, TX_EXPANDED}; // R9
      default: rb_byte = store[idx_r];
    endcase
  end

  // serial command interpreter
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d <= 1'b0;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
      bit_cnt_r <= 3'h0;
      shin_r <= 7'h00;
      shout_r <= 8'h00;
      st_r <= ST_CMD;
      idx_r <= 6'h00;
      last_r <= 6'h00;
      rd_kind_r <= `RD_STORE;
      tx_ts_r <= 5'h00;
      rx_ts_r <= 5'h00;
      tx_cs_r <= 3'h0;
      rx_cs_r <= 3'h0;
      rx_sel_r <= 1'b0;
      tx_sel_r <= 1'b0;
      SER_DOUT <= 1'b0;
      SER_DOUT_OE <= 1'b0;
      POWERED_UP <= 1'b0; // reset lands in standby
      DATA_RAM_CLEAR <= 1'b0;
      LATCHED_CONTROL_LINES <= `RST_LATCH;
      FILTER_ENABLES <= `RST_FILT;
      LINEAR_CODE <= 1'b0;
      RX_EXPANDED <= 1'b0;
      TX_EXPANDED <= 1'b0;
      LOOP_ANALOG <= 1'b0;
      LOOP_DIGITAL <= 1'b0;
      RX_ATTEN_6DB <= 1'b0;
      RX_PATH_CUT <= 1'b0;
      HPF_OFF <= 1'b0;
      CODE_ILLEGAL <= 1'b0;
      for (i = 0; i < `STORE_WORDS; i = i + 1)
        store[i] <= 8'h00;
    end else begin
      cs_s1 <= SER_CS_N;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      ck_s1 <= SER_CMD_CLOCK;
      ck_s2 <= ck_s1;
      ck_d <= ck_s2;
      di_s1 <= SER_DIN;
      di_s2 <= di_s1;
      DATA_RAM_CLEAR <= 1'b0;
      // a select window frames exactly one byte
      if (cs_s2) begin
        bit_cnt_r <= 3'h0;
      end else if (ck_rise) begin
        shin_r <= nb[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      // output side: load at select fall, shift on falling clock
      if (cs_rise) begin
        SER_DOUT_OE <= 1'b0; // R22
      end else if (cs_fall && st_r == ST_READ) begin
        shout_r <= rb_byte; // R6
        SER_DOUT <= rb_byte[7]; // R24
        SER_DOUT_OE <= 1'b1;
        if (idx_r == last_r)
          st_r <= ST_CMD;
        else
          idx_r <= idx_r + 6'h01;
      end else if (ck_fall && SER_DOUT_OE) begin
        shout_r <= {shout_r[6:0], 1'b0};
        SER_DOUT <= shout_r[6];
      end
      // input bytes; nothing is taken while a result goes out
      if (byte_done && !SER_DOUT_OE && st_r == ST_PARAM) begin
        if (nb == `CMD_POWER_DOWN) begin
          store[last_r] <= 8'h00; // R7
          POWERED_UP <= 1'b0; // R7
          st_r <= ST_CMD;
        end else begin
          store[idx_r] <= nb; // R5
          if (nb[3:0] == 4'h0 || nb[7:4] == 4'h0)
            CODE_ILLEGAL <= 1'b1; // R15
          if (idx_r == last_r)
            st_r <= ST_CMD;
          else
            idx_r <= idx_r + 6'h01;
        end
      end else if (byte_done && !SER_DOUT_OE && st_r == ST_CMD) begin
        case (nb[7:5]) // R23
          `CLS_PDN: begin
            if (nb == `CMD_POWER_DOWN)
              POWERED_UP <= 1'b0; // R3
          end // other codes reserved R25
          `CLS_TX_SLOT: tx_ts_r <= sub; // R4
          `CLS_RX_SLOT: rx_ts_r <= sub; // R4
          `CLS_CLK_GAIN: begin
            if (sub[4:3] == 2'h0) begin
              tx_cs_r <= sub[2:0]; // R4
            end else if (sub[4:3] == 2'h1) begin
              rx_cs_r <= sub[2:0]; // R4
            end else begin
              case (sub)
                `SUB_TXG_WR: begin
                  st_r <= ST_PARAM; // R5
                  idx_r <= `BASE_TXG;
                  last_r <= `LAST_TXG;
                end
                `SUB_RXG_WR: begin
                  st_r <= ST_PARAM; // R5
                  idx_r <= `BASE_RXG;
                  last_r <= `LAST_RXG;
                end
                `SUB_RD_TXSLOT: begin
                  st_r <= ST_READ; // R8
                  rd_kind_r <= `RD_TXSLOT;
                  idx_r <= 6'h00;
                  last_r <= 6'h01;
                end
                `SUB_RD_RXSLOT: begin
                  st_r <= ST_READ; // R8
                  rd_kind_r <= `RD_RXSLOT;
                  idx_r <= 6'h00;
                  last_r <= 6'h01;
                end
                `SUB_RD_TXG: begin
                  st_r <= ST_READ; // R6
                  rd_kind_r <= `RD_STORE;
                  idx_r <= `BASE_TXG;
                  last_r <= `LAST_TXG;
                end
                `SUB_RD_RXG: begin
                  st_r <= ST_READ; // R6
                  rd_kind_r <= `RD_STORE;
                  idx_r <= `BASE_RXG;
                  last_r <= `LAST_RXG;
                end
                `SUB_RD_MODE: begin
                  st_r <= ST_READ; // R9
                  rd_kind_r <= `RD_MODE;
                  idx_r <= 6'h00;
                  last_r <= 6'h00;
                end
                default: st_r <= ST_CMD; // R25
              endcase
            end
          end
          `CLS_FUNC: begin
            if (!sub[4]) begin
              FILTER_ENABLES <= sub[3:0]; // R10
            end else begin
              rx_sel_r <= sub[3]; // R11
              tx_sel_r <= sub[2]; // R11
              RX_EXPANDED <= sub[1]; // R11
              TX_EXPANDED <= sub[0]; // R11
            end
          end
          `CLS_COEF_TEST: begin
            // write and read of coefficient sets share one path
            case (sub)
              `SUB_WR_B, `SUB_RD_B: begin
                st_r <= (sub == `SUB_WR_B) ? ST_PARAM : ST_READ; // R17
                rd_kind_r <= `RD_STORE;
                idx_r <= `BASE_B;
                last_r <= `LAST_B;
              end
              `SUB_WR_X, `SUB_RD_X: begin
                st_r <= (sub == `SUB_WR_X) ? ST_PARAM : ST_READ; // R16
                rd_kind_r <= `RD_STORE;
                idx_r <= `BASE_X;
                last_r <= `LAST_X;
              end
              `SUB_WR_R, `SUB_RD_R: begin
                st_r <= (sub == `SUB_WR_R) ? ST_PARAM : ST_READ; // R16
                rd_kind_r <= `RD_STORE;
                idx_r <= `BASE_R;
                last_r <= `LAST_R;
              end
              `SUB_WR_Z, `SUB_RD_Z: begin
                st_r <= (sub == `SUB_WR_Z) ? ST_PARAM : ST_READ; // R16
                rd_kind_r <= `RD_STORE;
                idx_r <= `BASE_Z;
                last_r <= `LAST_Z;
              end
              `SUB_NORMAL: begin
                RX_ATTEN_6DB <= 1'b0; // R13
                RX_PATH_CUT <= 1'b0; // R13
                HPF_OFF <= 1'b0; // R13
                LOOP_ANALOG <= 1'b0; // R14
                LOOP_DIGITAL <= 1'b0; // R14
              end
              `SUB_ATTN: RX_ATTEN_6DB <= 1'b1;
              `SUB_RXCUT: RX_PATH_CUT <= 1'b1;
              `SUB_HPF_OFF: HPF_OFF <= 1'b1;
              `SUB_LOOP_ANA: begin
                LOOP_ANALOG <= 1'b1;
                LOOP_DIGITAL <= 1'b0; // R14
              end
              `SUB_LOOP_DIG: begin
                LOOP_DIGITAL <= 1'b1;
                LOOP_ANALOG <= 1'b0; // R14
              end
              `SUB_LINEAR: LINEAR_CODE <= 1'b1;
              `SUB_MULAW: LINEAR_CODE <= 1'b0;
              default: st_r <= ST_CMD; // R25
            endcase
          end
          `CLS_LATCH: LATCHED_CONTROL_LINES <= sub; // R22
          default: begin
            if (nb == `CMD_POWER_UP) begin
              POWERED_UP <= 1'b1; // R3
              DATA_RAM_CLEAR <= 1'b1; // R2
            end
          end
        endcase
      end
    end
  end

  // transmit highway side
  reg tck_s1, tck_s2, tck_d, tfs_s1, tfs_s2, tfs_prev_r;
  reg [9:0] tpos_r; // bit clocks since transmit frame start
  reg [1:0] tsync_cnt_r; // syncs seen since power up
  reg [15:0] tsh_r; // outgoing sample
  reg [4:0] tleft_r; // bits still to send
  reg tact_r; // burst in progress
  wire [15:0] fifo_data;
  wire fifo_valid;
  reg fifo_pop;
  wire tck_rise = tck_s2 & ~tck_d;
  wire tframe = tfs_s2 & ~tfs_prev_r; // R21
  wire [9:0] tpos_nxt = tframe ? 10'h000 :
                        (tpos_r == `POS_MAX ? tpos_r : tpos_r + 10'h001);
  wire [9:0] tstart = {2'h0, tx_ts_r, 3'h0} + {7'h00, tx_cs_r}; // R4
  wire [4:0] nbits = LINEAR_CODE ? `BITS_LIN : `BITS_MU;
  // looped samples are doubled, i.e. 6 dB up, in linear code
  wire [15:0] loop_word = LINEAR_CODE ? {RX_SAMPLE_DATA[14:0], 1'b0}
                                      : {RX_SAMPLE_DATA[7:0], 8'h00}; // R18
  wire [15:0] src_word = fifo_valid ? fifo_data : 16'h0000;
  wire [15:0] tword = LOOP_DIGITAL ? loop_word :
                      (LINEAR_CODE ? src_word : {src_word[7:0], 8'h00});

  sample_fifo #(.W(16), .D(4), .AW(2)) u_tx_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_data(TX_SAMPLE_DATA),
    .in_valid(TX_SAMPLE_VALID),
    .in_ready(TX_SAMPLE_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // bursts launch and shift on rising transmit bit clock edges
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_d <= 1'b0;
      tfs_s1 <= 1'b0;
      tfs_s2 <= 1'b0;
      tfs_prev_r <= 1'b0;
      tpos_r <= `POS_MAX;
      tsync_cnt_r <= 2'h0;
      tsh_r <= 16'h0000;
      tleft_r <= 5'h00;
      tact_r <= 1'b0;
      fifo_pop <= 1'b0;
      TX_PORT_FIRST <= 1'b0;
      TX_PORT_SECOND <= 1'b0;
      TX_PORT_FIRST_OE <= 1'b0;
      TX_PORT_SECOND_OE <= 1'b0;
      SLOT_STROBE_FIRST <= 1'b0;
      SLOT_STROBE_SECOND <= 1'b0;
      SLOT_STROBE_FIRST_OE <= 1'b0;
      SLOT_STROBE_SECOND_OE <= 1'b0;
    end else begin
      tck_s1 <= TX_BIT_CLOCK;
      tck_s2 <= tck_s1;
      tck_d <= tck_s2;
      tfs_s1 <= TX_FRAME_SYNC;
      tfs_s2 <= tfs_s1;
      fifo_pop <= 1'b0;
      if (DATA_RAM_CLEAR)
        tsync_cnt_r <= 2'h0; // R2
      else if (tck_rise && tframe && tsync_cnt_r != `TX_ARM_SYNCS)
        tsync_cnt_r <= tsync_cnt_r + 2'h1; // R2
      if (!POWERED_UP) begin
        tact_r <= 1'b0; // R1
        TX_PORT_FIRST_OE <= 1'b0; // R1
        TX_PORT_SECOND_OE <= 1'b0; // R1
        SLOT_STROBE_FIRST_OE <= 1'b0;
        SLOT_STROBE_SECOND_OE <= 1'b0;
      end else if (tck_rise) begin
        tfs_prev_r <= tfs_s2;
        tpos_r <= tpos_nxt;
        if (!tact_r && tpos_nxt == tstart &&
            tsync_cnt_r == `TX_ARM_SYNCS) begin
          tact_r <= 1'b1; // R19
          tsh_r <= {tword[14:0], 1'b0};
          tleft_r <= nbits - 5'h01;
          fifo_pop <= fifo_valid & ~LOOP_DIGITAL;
          TX_PORT_FIRST <= tword[15];
          TX_PORT_SECOND <= tword[15];
          TX_PORT_FIRST_OE <= ~tx_sel_r; // R19
          TX_PORT_SECOND_OE <= tx_sel_r; // R19
          SLOT_STROBE_FIRST_OE <= ~tx_sel_r; // R12
          SLOT_STROBE_SECOND_OE <= tx_sel_r; // R12
        end else if (tact_r && tleft_r == 5'h00) begin
          tact_r <= 1'b0;
          TX_PORT_FIRST_OE <= 1'b0; // R19
          TX_PORT_SECOND_OE <= 1'b0; // R19
          SLOT_STROBE_FIRST_OE <= 1'b0; // R12
          SLOT_STROBE_SECOND_OE <= 1'b0; // R12
        end else if (tact_r) begin
          tleft_r <= tleft_r - 5'h01;
          tsh_r <= {tsh_r[14:0], 1'b0};
          TX_PORT_FIRST <= tsh_r[15];
          TX_PORT_SECOND <= tsh_r[15];
        end
      end
    end
  end

  // receive highway side, sampled on falling receive bit clock edges
  reg rck_s1, rck_s2, rck_d, rfs_s1, rfs_s2, rfs_prev_r;
  reg rxa_s1, rxa_s2, rxb_s1, rxb_s2;
  reg [9:0] rpos_r; // bit clocks since receive frame start
  reg [15:0] rsh_r; // incoming sample
  reg [4:0] rleft_r; // bits still to take
  reg ract_r; // burst in progress
  wire rck_fall = ~rck_s2 & rck_d;
  wire rframe = rfs_s2 & ~rfs_prev_r; // R21
  wire [9:0] rpos_nxt = rframe ? 10'h000 :
                        (rpos_r == `POS_MAX ? rpos_r : rpos_r + 10'h001);
  wire [9:0] rstart = {2'h0, rx_ts_r, 3'h0} + {7'h00, rx_cs_r}; // R4
  wire rbit = rx_sel_r ? rxb_s2 : rxa_s2; // R11
  wire [15:0] rword = {rsh_r[14:0], rbit};

  always @(posedge CORE_CLK) begin
    if (RESET) begin
      rck_s1 <= 1'b0;
      rck_s2 <= 1'b0;
      rck_d <= 1'b0;
      rfs_s1 <= 1'b0;
      rfs_s2 <= 1'b0;
      rfs_prev_r <= 1'b0;
      rxa_s1 <= 1'b0;
      rxa_s2 <= 1'b0;
      rxb_s1 <= 1'b0;
      rxb_s2 <= 1'b0;
      rpos_r <= `POS_MAX;
      rsh_r <= 16'h0000;
      rleft_r <= 5'h00;
      ract_r <= 1'b0;
      RX_SAMPLE_DATA <= 16'h0000;
      RX_SAMPLE_VALID <= 1'b0;
    end else begin
      rck_s1 <= RX_BIT_CLOCK;
      rck_s2 <= rck_s1;
      rck_d <= rck_s2;
      rfs_s1 <= RX_FRAME_SYNC;
      rfs_s2 <= rfs_s1;
      rxa_s1 <= RX_PORT_FIRST;
      rxa_s2 <= rxa_s1;
      rxb_s1 <= RX_PORT_SECOND;
      rxb_s2 <= rxb_s1;
      RX_SAMPLE_VALID <= 1'b0;
      if (DATA_RAM_CLEAR) begin
        RX_SAMPLE_DATA <= 16'h0000; // R2
        ract_r <= 1'b0;
      end else if (!POWERED_UP) begin
        ract_r <= 1'b0; // R1
      end else if (rck_fall) begin
        rfs_prev_r <= rfs_s2;
        rpos_r <= rpos_nxt;
        if (!ract_r && rpos_nxt == rstart) begin
          ract_r <= 1'b1; // R20
          rsh_r <= {15'h0000, rbit};
          rleft_r <= nbits - 5'h01;
        end else if (ract_r) begin
          rsh_r <= rword;
          rleft_r <= rleft_r - 5'h01;
          if (rleft_r == 5'h01) begin
            ract_r <= 1'b0;
            RX_SAMPLE_DATA <= rword; // R20
            RX_SAMPLE_VALID <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### verif/line_codec_serial_control_assertions.sv
/* Checker bound to the line codec serial control block.
   Assumes it sees only top-level ports of that block. */
`timescale 1ns/10ps
module line_codec_checker (
  // clock, reset and watched ports
  input wire CORE_CLK, RESET, SER_CS_N, SER_DOUT_OE, POWERED_UP,
  input wire TX_PORT_FIRST_OE, TX_PORT_SECOND_OE, DATA_RAM_CLEAR,
  input wire SLOT_STROBE_FIRST_OE, SLOT_STROBE_SECOND_OE, LINEAR_CODE,
  input wire LOOP_ANALOG, LOOP_DIGITAL, RX_SAMPLE_VALID
);
  logic [7:0] len_r; // cycles the second tx port has been driven
  // burst length counter, cleared whenever the port is released
  always_ff @(posedge CORE_CLK)
    len_r <= (RESET || !TX_PORT_SECOND_OE) ? 8'h00 : len_r + 8'h01;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // a burst cut by power-down may lag one cycle, hence the $past
  standby_quiet_a: assert property (!POWERED_UP && !$past(POWERED_UP)
    |-> !TX_PORT_FIRST_OE && !TX_PORT_SECOND_OE) else $error("tx in standby");
  strobe_follows_a: assert property (
    SLOT_STROBE_FIRST_OE == TX_PORT_FIRST_OE &&
    SLOT_STROBE_SECOND_OE == TX_PORT_SECOND_OE) else $error("bad strobe");
  one_port_a: assert property (!(TX_PORT_FIRST_OE && TX_PORT_SECOND_OE))
    else $error("both tx ports");
  loop_exclusive_a: assert property (!(LOOP_ANALOG && LOOP_DIGITAL))
    else $error("two loopbacks");
  ram_clear_a: assert property (DATA_RAM_CLEAR |=>
    !DATA_RAM_CLEAR && POWERED_UP) else $error("bad clear pulse");
  burst_length_a: assert property (
    $fell(TX_PORT_SECOND_OE) && POWERED_UP && !LINEAR_CODE |->
    len_r inside {[63:65]}) else $error("bad burst length");
  dout_release_a: assert property (SER_CS_N [*6] |-> !SER_DOUT_OE)
    else $error("dout held");
  rx_pulse_a: assert property (RX_SAMPLE_VALID |=> !RX_SAMPLE_VALID)
    else $error("rx valid held");
endmodule
bind line_codec_serial_control line_codec_checker i_chk (.*);

// ### verif/pcm_highway_model.sv
/* PCM highway model: shared bit clock, both frame syncs, rx slot data.
   Assumes the bench reads the tx ports and leaves rx slot at zero. */
`timescale 1ns/10ps
module pcm_highway_model #(
  parameter int F = 64 // bit clocks per frame, shortened to keep runs brief
) (
  // highway lines and the rx slot word
  output logic bclk, txs, rxs, rxd,
  input wire logic [7:0] w
);
  int pos_r = 0; // bit position in frame
  // free-running bit clock of eight core clock periods, edges at a fixed offset from the core clock
  initial begin
    bclk = 0;
    txs = 0;
    #7;
    forever #160 bclk = ~bclk;
  end
  // position and rx sync move on the rise, settled at the sampling fall
  always @(posedge bclk) pos_r <= (pos_r + 1) % F;
  assign rxs = pos_r == 0;
  // tx sync moves on the fall so the sampling rise sees it settled
  always @(negedge bclk) txs <= pos_r == 0;
  // slot bits MSB first, a toggling filler elsewhere so nothing is stale
  assign rxd = pos_r < 8 ? w[7 - pos_r] : pos_r[0];
endmodule

// ### verif/testbench.sv
/* Self-checking bench for the line codec serial control block.
   Assumes the design and the highway model are compiled first. */
`timescale 1ns/10ps
module testbench;
  // design inputs, all set at time zero
  logic CORE_CLK = 0, RESET = 1, SER_CS_N = 1, SER_CMD_CLOCK = 0;
  logic SER_DIN = 0, TX_SAMPLE_VALID = 0;
  logic [15:0] TX_SAMPLE_DATA = 16'h0000;
  wire TX_BIT_CLOCK, RX_BIT_CLOCK, TX_FRAME_SYNC, RX_FRAME_SYNC;
  wire RX_PORT_FIRST, RX_PORT_SECOND, SER_DOUT, SER_DOUT_OE, TX_PORT_FIRST;
  wire TX_PORT_FIRST_OE, TX_PORT_SECOND, TX_PORT_SECOND_OE, SLOT_STROBE_FIRST;
  wire SLOT_STROBE_FIRST_OE, SLOT_STROBE_SECOND, SLOT_STROBE_SECOND_OE;
  wire TX_SAMPLE_READY, RX_SAMPLE_VALID, POWERED_UP, DATA_RAM_CLEAR;
  wire LINEAR_CODE, RX_EXPANDED, TX_EXPANDED, LOOP_ANALOG, LOOP_DIGITAL;
  wire RX_ATTEN_6DB, RX_PATH_CUT, HPF_OFF, CODE_ILLEGAL;
  wire [15:0] RX_SAMPLE_DATA, TX_GAIN, RX_GAIN;
  wire [4:0] LATCHED_CONTROL_LINES;
  wire [3:0] FILTER_ENABLES;
  logic [7:0] rd; // byte shifted back by the last transfer or burst
  int err_total = 0, total_checks = 0, cycles = 0, syncs = 0, n, k;
  assign RX_BIT_CLOCK = TX_BIT_CLOCK;
  assign RX_PORT_SECOND = ~RX_PORT_FIRST; // unselected port differs
  line_codec_serial_control i_dut (.*);
  pcm_highway_model i_hw (.bclk(TX_BIT_CLOCK), .txs(TX_FRAME_SYNC),
    .rxs(RX_FRAME_SYNC), .rxd(RX_PORT_FIRST), .w(8'h3C));
  initial forever #20 CORE_CLK = ~CORE_CLK;
  // tx frame syncs since the last power-up
  always @(posedge TX_FRAME_SYNC) syncs++;
  always @(posedge POWERED_UP) syncs = 0;
  // hang guard
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      finish_test;
    end
  end
  task cyc(int c);
    repeat (c) @(posedge CORE_CLK);
  endtask
  task chk(logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one byte per select window, MSB first, reading back as it goes
  task xfer(logic [7:0] w);
    SER_CS_N <= 0;
    for (int i = 7; i >= 0; i--) begin
      SER_DIN <= w[i];
      cyc(6);
      rd[i] = SER_DOUT;
      SER_CMD_CLOCK <= 1;
      cyc(6);
      SER_CMD_CLOCK <= 0;
    end
    cyc(6);
    SER_CS_N <= 1;
    cyc(12);
  endtask
  // waits for a burst on the second port; samples at the next rises
  task burst(logic [7:0] e);
    for (int i = 0; i < 2000 && TX_PORT_SECOND_OE !== 1; i++) cyc(1);
    n = syncs;
    for (int i = 7; i >= 0; i--) begin
      @(posedge TX_BIT_CLOCK);
      rd[i] = TX_PORT_SECOND;
    end
    chk(rd, e);
    cyc(8);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(2);
    RESET <= 0;
    cyc(3);
    chk({POWERED_UP, LATCHED_CONTROL_LINES, FILTER_ENABLES}, 10'h1F0);
    xfer(8'h21);
    xfer(8'h63);
    xfer(8'h72);
    xfer(8'hFF);
    chk(rd, 8'h01);
    xfer(8'hFF);
    chk({POWERED_UP, rd}, 9'h003);
    xfer(8'h95);
    xfer(8'h76);
    xfer(8'hFF);
    chk({TX_EXPANDED, rd}, 9'h1F5);
    xfer(8'h8B);
    xfer(8'hD5);
    xfer(8'hB4);
    chk({FILTER_ENABLES, LATCHED_CONTROL_LINES, LOOP_DIGITAL}, 10'h2EB);
    xfer(8'hB1);
    xfer(8'hB7);
    chk({LOOP_ANALOG, LOOP_DIGITAL, RX_ATTEN_6DB}, 3'h5);
    xfer(8'hB0);
    xfer(8'h05);
    xfer(8'hE3);
    chk({LOOP_ANALOG, LOOP_DIGITAL, RX_ATTEN_6DB}, 3'h0);
    chk({POWERED_UP, LATCHED_CONTROL_LINES}, 6'h15);
    xfer(8'hA4);
    for (k = 1; k < 9; k++) xfer(8'(8'h11 * k));
    xfer(8'hA7);
    for (k = 1; k < 9; k++) begin
      xfer(8'hFF);
      chk(rd, 8'(8'h11 * k));
    end
    xfer(8'hA0);
    for (k = 0; k < 12; k++) xfer(k ? 8'h77 : 8'h10);
    xfer(8'hD3);
    chk({CODE_ILLEGAL, LATCHED_CONTROL_LINES}, 6'h33);
    xfer(8'hFF);
    n = 0;
    repeat (6) begin
      TX_SAMPLE_DATA <= 16'(16'hA5 + n);
      TX_SAMPLE_VALID <= 1;
      cyc(1);
      if (TX_SAMPLE_READY === 1) n++;
    end
    TX_SAMPLE_VALID <= 0;
    chk({POWERED_UP, n[3:0]}, 5'h14);
    for (k = 0; k < 5; k++) begin
      burst(k < 4 ? 8'(8'hA5 + k) : 8'h00);
      if (k == 0) chk(n[3:0], 4'h2);
    end
    for (k = 0; k < 2000 && RX_SAMPLE_VALID !== 1; k++) cyc(1);
    chk(RX_SAMPLE_DATA[7:0], 8'h3C);
    xfer(8'h70);
    xfer(8'h12);
    xfer(8'h00);
    chk(TX_GAIN, 16'h1200);
    chk({POWERED_UP, FILTER_ENABLES}, 5'h0B);
    finish_test;
  end
endmodule
